/* File: hw/tmt_pkg.sv */
// package for the 16-bit timer/counter three block
package tmt_pkg;
  // register byte addresses
  localparam logic [11:0] TMT_ADDR_CTRL = 12'h000;
  localparam logic [11:0] TMT_ADDR_CNT_LO = 12'h004;
  localparam logic [11:0] TMT_ADDR_CNT_HI = 12'h008;
  localparam logic [11:0] TMT_ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] TMT_ADDR_IRQ_EN = 12'h010;
  localparam logic [11:0] TMT_ADDR_IRQ_CLR = 12'h014;
  // control field positions
  localparam int TMT_BIT_ATOMIC = 7;
  localparam int TMT_BIT_CSEL_HI = 6;
  localparam int TMT_BIT_PS_HI = 5;
  localparam int TMT_BIT_PS_LO = 4;
  localparam int TMT_BIT_CSEL_LO = 3;
  localparam int TMT_BIT_SYNC_DIS = 2;
  localparam int TMT_BIT_CLK_SRC = 1;
  localparam int TMT_BIT_RUN = 0;
  // reset values and special event compare mode
  localparam logic [7:0] TMT_CTRL_RST = 8'h00;
  localparam logic [15:0] TMT_CNT_RST = 16'h0000;
  localparam logic [2:0] TMT_PS_RST = 3'h0;
  localparam logic [3:0] TMT_CMP_SPECIAL = 4'hB;
  // control register layout
  typedef struct packed {
    logic atomic_access_select;
    logic capture_source_sel_hi;
    logic [1:0] prescale_select;
    logic capture_source_sel_lo;
    logic sync_disable;
    logic clock_source_select;
    logic run_enable;
  } tmt_ctrl_t;
  // compare unit trigger inputs
  typedef struct packed {
    logic [3:0] mode;
    logic match;
  } tmt_cmp_t;
  // external clock edge tracker
  typedef enum logic [1:0] {
    TMT_EDGE_ARM = 2'b00,
    TMT_EDGE_LOW = 2'b01,
    TMT_EDGE_HIGH = 2'b11
  } tmt_edge_t;
endpackage

/* File: hw/tmt_timer.sv */
// 16-bit timer/counter three with apb register access
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - atomic bit on gives 16-bit access, off gives two byte accesses
// - two-bit source field picks timer for each capture/compare unit
// - prescale field divides by 1, 2, 4 or 8
// - sync disable passes external clock raw; ignored for internal clock
// - source zero counts instruction cycles; one counts external rising edges
// - run enable low stops counting and holds the count
// - oscillator enabled makes both oscillator pins inputs reading zero
// - atomic low byte read snapshots live high byte into buffer
// - atomic high write loads buffer; low write moves both bytes
// - in atomic mode high byte only through the buffer
// - low byte write clears prescaler; high byte write does not
// - crystal clocks counter only when oscillator enable and source set
// - count wraps from maximum to zero and sets sticky overflow flag
// - overflow flag requests interrupt only while its enable is set
// - special event compare match resets the count to zero
// - software write wins over coincident special-event reset
// - special-event reset never sets the overflow flag
module tmt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic crystal_osc_enable,
  input wire logic crystal_osc_clk,
  input wire tmt_pkg::tmt_cmp_t cmp_unit1,
  input wire tmt_pkg::tmt_cmp_t cmp_unit2,
  input wire logic [1:0] osc_pin_in,
  output logic [1:0] osc_pin_read,
  output logic [1:0] osc_pin_force_input,
  output logic unit1_uses_this,
  output logic unit2_uses_this,
  output logic irq
);
  import tmt_pkg::*;

  tmt_ctrl_t ctrl_r;
  logic [15:0] cnt_r;
  logic [7:0] hbuf_r;
  logic [2:0] ps_r;
  logic ovf_r;
  logic ovf_en_r;
  logic sync1_r, sync2_r;
  tmt_edge_t edge_r, edge_nxt;

  // apb decode
  wire logic acc = psel & penable & clk_en;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  wire logic hit_ctrl = (paddr == TMT_ADDR_CTRL);
  wire logic hit_lo = (paddr == TMT_ADDR_CNT_LO);
  wire logic hit_hi = (paddr == TMT_ADDR_CNT_HI);
  wire logic hit_stat = (paddr == TMT_ADDR_IRQ_STAT);
  wire logic hit_en = (paddr == TMT_ADDR_IRQ_EN);
  wire logic hit_clr = (paddr == TMT_ADDR_IRQ_CLR);
  wire logic mapped = hit_ctrl | hit_lo | hit_hi | hit_stat | hit_en | hit_clr;
  wire logic wr_lo = wr & hit_lo;
  wire logic wr_hi = wr & hit_hi;
  wire logic rd_lo = rd & hit_lo;
  // access width select: a count write is a low write, or a direct high write
  wire logic cnt_wr = wr_lo | (wr_hi & ~ctrl_r.atomic_access_select);

  // clock source selection
  // crystal path select
  wire logic ext_src = crystal_osc_enable ? crystal_osc_clk : external_count_input;
  wire logic ext_lvl = ctrl_r.sync_disable ? ext_src : sync2_r;

  // edge tracker: counts only rising edges after a falling edge
  always_comb begin
    edge_nxt = edge_r;
    case (edge_r)
      TMT_EDGE_ARM: if (!ext_lvl) edge_nxt = TMT_EDGE_LOW;
      TMT_EDGE_LOW: if (ext_lvl) edge_nxt = TMT_EDGE_HIGH;
      TMT_EDGE_HIGH: if (!ext_lvl) edge_nxt = TMT_EDGE_LOW;
      default: edge_nxt = TMT_EDGE_ARM;
    endcase
  end
  wire logic ext_rise = (edge_r == TMT_EDGE_LOW) & ext_lvl;

  wire logic src_tick = ctrl_r.clock_source_select ? ext_rise : 1'b1;

  function automatic logic ps_done(input logic [1:0] sel, input logic [2:0] cnt);
    case (sel)
      2'b00: ps_done = 1'b1;
      2'b01: ps_done = (cnt[0] == 1'b1);
      2'b10: ps_done = (cnt[1:0] == 2'b11);
      default: ps_done = (cnt == 3'b111);
    endcase
  endfunction

  wire logic tick = ctrl_r.run_enable & src_tick;
  wire logic inc = tick & ps_done(ctrl_r.prescale_select, ps_r);
  wire logic wrap = inc & (cnt_r == 16'hFFFF);

  wire logic u1_this = ctrl_r.capture_source_sel_hi;
  wire logic u2_this = ctrl_r.capture_source_sel_hi | ctrl_r.capture_source_sel_lo;
  wire logic sev = (u1_this & cmp_unit1.match & (cmp_unit1.mode == TMT_CMP_SPECIAL))
                 | (u2_this & cmp_unit2.match & (cmp_unit2.mode == TMT_CMP_SPECIAL));

  // count next value
  logic [15:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (inc) cnt_nxt = cnt_r + 16'h0001;
    // reset to zero, skipped when a count write shares the cycle
    if (sev & ~cnt_wr) cnt_nxt = TMT_CNT_RST;
    if (wr_hi & ~ctrl_r.atomic_access_select) cnt_nxt[15:8] = pwdata[7:0];
    if (wr_lo) begin
      cnt_nxt[7:0] = pwdata[7:0];
      if (ctrl_r.atomic_access_select) cnt_nxt[15:8] = hbuf_r;
    end
  end

  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) rd_byte = ctrl_r;
    if (hit_lo) rd_byte = cnt_r[7:0];
    if (hit_hi) rd_byte = ctrl_r.atomic_access_select ? hbuf_r : cnt_r[15:8];
    if (hit_stat) rd_byte = {7'h00, ovf_r};
    if (hit_en) rd_byte = {7'h00, ovf_en_r};
  end

  // synchroniser and edge state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      edge_r <= TMT_EDGE_ARM;
    end else if (clk_en) begin
      sync1_r <= ext_src;
      sync2_r <= sync1_r;
      edge_r <= edge_nxt;
    end
  end

  // control, count, prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= TMT_CTRL_RST;
      cnt_r <= TMT_CNT_RST;
      ps_r <= TMT_PS_RST;
    end else if (clk_en) begin
      if (wr & hit_ctrl) ctrl_r <= pwdata[7:0];
      cnt_r <= cnt_nxt;
      if (wr_lo) ps_r <= TMT_PS_RST;
      else if (tick) ps_r <= ps_r + 3'h1;
    end
  end

  // high byte buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hbuf_r <= 8'h00;
    end else if (clk_en) begin
      if (rd_lo & ctrl_r.atomic_access_select) hbuf_r <= cnt_r[15:8];
      else if (wr_hi & ctrl_r.atomic_access_select) hbuf_r <= pwdata[7:0];
    end
  end

  // overflow flag and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
      ovf_en_r <= 1'b0;
    end else if (clk_en) begin
      // set wins over clear, only real wrap
      if (wrap & ~sev & ~wr_lo) ovf_r <= 1'b1;
      else if (wr & hit_clr & pwdata[0]) ovf_r <= 1'b0;
      if (wr & hit_en) ovf_en_r <= pwdata[0];
    end
  end

  // outputs and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      osc_pin_read <= 2'b00;
      osc_pin_force_input <= 2'b00;
      unit1_uses_this <= 1'b0;
      unit2_uses_this <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= {24'h00_0000, rd_byte};
      // pins forced to input, read zero
      osc_pin_force_input <= {2{crystal_osc_enable}};
      osc_pin_read <= crystal_osc_enable ? 2'b00 : osc_pin_in;
      unit1_uses_this <= u1_this;
      unit2_uses_this <= u2_this;
      irq <= (ovf_r | (wrap & ~sev & ~wr_lo)) & ovf_en_r;
    end
  end

  // assertions
  property p_run_hold;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ~ctrl_r.run_enable & ~sev & ~wr_lo & ~wr_hi) |=> $stable(cnt_r);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

  property p_wrap_flag;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & wrap & ~sev & ~wr_lo & ~wr_hi) |=> (ovf_r && cnt_r == 16'h0000);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

  property p_sev_reset;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & sev & ~wr_lo & ~wr_hi & ~ovf_r) |=> (cnt_r == 16'h0000 && !ovf_r);
  endproperty
  a_sev_reset: assert property (p_sev_reset) else $error("special reset wrong");

  property p_write_wins;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & sev & wr_lo) |=> (cnt_r[7:0] == $past(pwdata[7:0]));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to reset");

  property p_snapshot;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & rd_lo & ctrl_r.atomic_access_select) |=> (hbuf_r == $past(cnt_r[15:8]));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("no high byte snapshot");

  property p_ps_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & wr_lo) |=> (ps_r == 3'h0);
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ~ovf_en_r) |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

  property p_osc_pins;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & crystal_osc_enable) |=> (osc_pin_read == 2'b00 && osc_pin_force_input == 2'b11);
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("osc pins not forced");

  property p_atomic_hi;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & wr_hi & ctrl_r.atomic_access_select & ~wr_lo & ~sev & ~inc) |=> $stable(cnt_r);
  endproperty
  a_atomic_hi: assert property (p_atomic_hi) else $error("live high byte written");

  // routing outputs follow the source field
  property p_route;
    @(posedge pclk) disable iff (!presetn)
      clk_en |=> (unit1_uses_this == $past(u1_this) && unit2_uses_this == $past(u2_this));
  endproperty
  a_route: assert property (p_route) else $error("time base routing wrong");

  // prescaler steps on every tick without a low byte write
  property p_ps_step;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & tick & ~wr_lo) |=> (ps_r == $past(ps_r) + 3'h1);
  endproperty
  a_ps_step: assert property (p_ps_step) else $error("prescaler did not step");

  // divide by eight holds count between terminals
  property p_ps_div8;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & tick & (ctrl_r.prescale_select == 2'b11) & (ps_r != 3'h7) & ~wr_lo & ~wr_hi & ~sev) |=> $stable(cnt_r);
  endproperty
  a_ps_div8: assert property (p_ps_div8) else $error("count moved inside prescale");

  // internal source at divide by one counts every cycle
  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ctrl_r.run_enable & ~ctrl_r.clock_source_select & (ctrl_r.prescale_select == 2'b00)
        & ~wr_lo & ~wr_hi & ~sev) |=> (cnt_r == $past(cnt_r) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("internal count did not step");

  // external source without a rising edge holds
  property p_ext_gap;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ctrl_r.clock_source_select & ~ext_rise & ~wr_lo & ~wr_hi & ~sev) |=> $stable(cnt_r);
  endproperty
  a_ext_gap: assert property (p_ext_gap) else $error("count without external edge");

  // atomic low write moves both bytes
  property p_atomic_lo;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & wr_lo & ctrl_r.atomic_access_select) |=> (cnt_r == {$past(hbuf_r), $past(pwdata[7:0])});
  endproperty
  a_atomic_lo: assert property (p_atomic_lo) else $error("paired write wrong");

  // direct high write outside atomic mode
  property p_direct_hi;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & wr_hi & ~ctrl_r.atomic_access_select) |=> (cnt_r[15:8] == $past(pwdata[7:0]));
  endproperty
  a_direct_hi: assert property (p_direct_hi) else $error("direct high write lost");

  // flag stays until cleared
  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ovf_r & ~(wr & hit_clr & pwdata[0])) |=> ovf_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");

  // enabled flag raises the request
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ovf_r & ovf_en_r) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing while enabled");

  // released oscillator pins read the port
  property p_osc_release;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ~crystal_osc_enable) |=> (osc_pin_read == $past(osc_pin_in) && osc_pin_force_input == 2'b00);
  endproperty
  a_osc_release: assert property (p_osc_release) else $error("osc pins not released");

  // clock enable low freezes state
  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
      !clk_en |=> ($stable(cnt_r) && $stable(ovf_r) && $stable(irq));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // setup phase answered in the access phase
  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & psel & ~penable) |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer missing");

  // main scenario covers
  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap);
  c_atomic: cover property (@(posedge pclk) disable iff (!presetn) rd_lo & ctrl_r.atomic_access_select);
  c_ext: cover property (@(posedge pclk) disable iff (!presetn) ext_rise & ctrl_r.clock_source_select & inc);
  c_sev: cover property (@(posedge pclk) disable iff (!presetn) sev & inc);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // tmt_timer

`default_nettype wire

/* File: tb/tmt_ccp_model.sv */
// compare unit pair model that raises special event matches on request
`timescale 1ns/1ns
`default_nettype none
module tmt_ccp_model
  import tmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] fire,
  output tmt_pkg::tmt_cmp_t cmp_unit1,
  output tmt_pkg::tmt_cmp_t cmp_unit2
);
  // one match pulse per request, mode held at special event
  // only fired while the bench runs timer mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_unit1 <= '0;
      cmp_unit2 <= '0;
    end else begin
      cmp_unit1 <= '{mode: TMT_CMP_SPECIAL, match: fire[0]};
      cmp_unit2 <= '{mode: TMT_CMP_SPECIAL, match: fire[1]};
    end
  end
endmodule // tmt_ccp_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the timer three block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  import tmt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext, osc_en, irq, u1, u2, note_v, rerr, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] pin_in, pin_rd, pin_fi, fire;
  logic [7:0] rv, lo, hi;
  logic [15:0] v;
  tmt_cmp_t c1, c2;
  int n_fail, tests_run, dummy;
  logic [7:0] q[$];
  // clock generation
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  tmt_timer u_tmt_timer (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(ext), .crystal_osc_enable(osc_en), .crystal_osc_clk(1'b0), .cmp_unit1(c1),
    .cmp_unit2(c2), .osc_pin_in(pin_in), .osc_pin_read(pin_rd), .osc_pin_force_input(pin_fi),
    .unit1_uses_this(u1), .unit2_uses_this(u2), .irq(irq));
  tmt_ccp_model u_tmt_ccp_model (.pclk(pclk), .presetn(presetn), .fire(fire), .cmp_unit1(c1), .cmp_unit2(c2));
  // apb transfer; held until pready, released, then one idle edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic nt);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0000_00, d};
    note_v <= nt;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata[7:0];
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1, a, d, 0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back(e);
    xfer(0, a, 8'h00, 1);
  endtask
  task automatic rng(input logic [11:0] a, input int lo_b, input int hi_b);
    xfer(0, a, 8'h00, 0);
    `CHK((int'(rv) >= lo_b && int'(rv) <= hi_b), 1'b1)
  endtask
  // read monitor takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && note_v && q.size() > 0)
      `CHK(prdata[7:0], q.pop_front())
  end
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400_000;
    n_fail++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, note_v, ext, osc_en} = '0;
    paddr = '0;
    pwdata = '0;
    pin_in = 2'b10;
    ce = 1'b1;
    fire = 2'b00;
    dummy = $urandom(32'hcdb1_ceb5);
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(TMT_ADDR_CTRL, 8'h00);
    rd(TMT_ADDR_IRQ_STAT, 8'h00);
    xfer(0, 12'h020, 8'h00, 0);
    `CHK(rerr, 1'b1)
    v = 16'($urandom);
    wr(TMT_ADDR_CNT_LO, v[7:0]);
    wr(TMT_ADDR_CNT_HI, v[15:8]);
    rd(TMT_ADDR_CNT_LO, v[7:0]);
    rd(TMT_ADDR_CNT_HI, v[15:8]);
    // capture source select patterns
    for (int c = 0; c < 4; c++) begin
      wr(TMT_ADDR_CTRL, {1'b0, c[1], 2'b00, c[0], 3'b000});
      @(posedge pclk);
      `CHK(u1, c[1])
      `CHK(u2, c != 0)
    end
    // atomic snapshot and buffered write
    wr(TMT_ADDR_CTRL, 8'h00);
    wr(TMT_ADDR_CNT_LO, 8'hFF);
    wr(TMT_ADDR_CNT_HI, 8'h12);
    wr(TMT_ADDR_CTRL, 8'h80);
    rd(TMT_ADDR_CNT_LO, 8'hFF);
    wr(TMT_ADDR_CTRL, 8'h81);
    repeat (3) @(posedge pclk);
    rd(TMT_ADDR_CNT_HI, 8'h12);
    wr(TMT_ADDR_CNT_HI, 8'hAB);
    wr(TMT_ADDR_CTRL, 8'h00);
    rd(TMT_ADDR_CNT_HI, 8'h13);
    wr(TMT_ADDR_CTRL, 8'h80);
    wr(TMT_ADDR_CNT_LO, 8'hCD);
    wr(TMT_ADDR_CTRL, 8'h00);
    rd(TMT_ADDR_CNT_HI, 8'hAB);
    rd(TMT_ADDR_CNT_LO, 8'hCD);
    // prescale codes over a fixed run span
    for (int p = 0; p < 4; p++) begin
      wr(TMT_ADDR_CNT_HI, 8'h00);
      wr(TMT_ADDR_CNT_LO, 8'h00);
      wr(TMT_ADDR_CTRL, {2'b00, 2'(p), 4'b0001});
      repeat (64) @(posedge pclk);
      wr(TMT_ADDR_CTRL, 8'h00);
      rng(TMT_ADDR_CNT_LO, (67 >> p) - 2, (67 >> p) + 2);
    end
    // external edges, synchronised and raw
    for (int s = 0; s < 2; s++) begin
      wr(TMT_ADDR_CNT_LO, 8'h00);
      wr(TMT_ADDR_CTRL, {5'b00000, s[0], 2'b11});
      repeat (5) begin
        ext <= 1;
        repeat (4) @(posedge pclk);
        ext <= 0;
        repeat (4) @(posedge pclk);
      end
      wr(TMT_ADDR_CTRL, 8'h00);
      rng(TMT_ADDR_CNT_LO, 4, 5);
    end
    // wrap, flag, enable, clear
    wr(TMT_ADDR_CNT_LO, 8'hFF);
    wr(TMT_ADDR_CNT_HI, 8'hFF);
    wr(TMT_ADDR_CTRL, 8'h01);
    repeat (4) @(posedge pclk);
    wr(TMT_ADDR_CTRL, 8'h00);
    rd(TMT_ADDR_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b0)
    wr(TMT_ADDR_IRQ_EN, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(TMT_ADDR_IRQ_CLR, 8'h01);
    rd(TMT_ADDR_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    // special event reset from unit one
    wr(TMT_ADDR_CNT_HI, 8'hF0);
    wr(TMT_ADDR_CNT_LO, 8'h00);
    wr(TMT_ADDR_CTRL, 8'h41);
    fire <= 2'b01;
    @(posedge pclk) fire <= 2'b00;
    repeat (2) @(posedge pclk);
    wr(TMT_ADDR_CTRL, 8'h40);
    rd(TMT_ADDR_CNT_HI, 8'h00);
    rd(TMT_ADDR_IRQ_STAT, 8'h00);
    // clock enable low freezes the count
    wr(TMT_ADDR_CNT_LO, 8'h00);
    wr(TMT_ADDR_CTRL, 8'h01);
    ce <= 0;
    repeat (20) @(posedge pclk);
    ce <= 1;
    wr(TMT_ADDR_CTRL, 8'h00);
    rng(TMT_ADDR_CNT_LO, 3, 5);
    // oscillator pins
    osc_en <= 1;
    repeat (3) @(posedge pclk);
    `CHK(pin_fi, 2'b11)
    `CHK(pin_rd, 2'b00)
    osc_en <= 0;
    repeat (3) @(posedge pclk);
    `CHK(pin_rd, pin_in)
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
